// ### rtl/usr_map.svh
// Purpose: Register map, field positions and reset values of the synchronous serial block.
// Assumes: Byte address of a register is four times its index.
// Notes: Only the low byte of each 32-bit word is used.
`ifndef USR_MAP_SVH
`define USR_MAP_SVH
`define USR_IDX_IFLAG 8'h0C
`define USR_IDX_RXCTL 8'h18
`define USR_IDX_TXDAT 8'h19
`define USR_IDX_RXDAT 8'h1A
`define USR_IDX_IEN 8'h8C
`define USR_IDX_TXCTL 8'h98
`define USR_IDX_BAUD 8'h99
`define USR_B_RXDONE 5
`define USR_B_TXEMPTY 4
`define USR_B_PORTEN 7
`define USR_B_RX9EN 6
`define USR_B_SWEN 5
`define USR_B_CONTEN 4
`define USR_B_ADDRDET 3
`define USR_B_FRAMEERR 2
`define USR_B_OVERRUN 1
`define USR_B_RX9BIT 0
`define USR_B_CLKSRC 7
`define USR_B_TX9EN 6
`define USR_B_TRANSMIT_ENABLE_BIT 5
`define USR_B_SYNCMODE 4
`define USR_B_HIBAUD 2
`define USR_B_SHEMPTY 1
`define USR_B_TX9BIT 0
`define USR_RST_BYTE 8'h00
`define USR_LAST_8BIT 4'h7
`define USR_LAST_9BIT 4'h8
`endif

// ### rtl/usr_pkg.sv
// Purpose: Types shared by the synchronous serial block.
// Assumes: Nothing beyond the register map header.
// Notes: Sequencer states use explicit binary codes.
package usr_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RX = 2'h1,
    ST_TX = 2'h2
  } usr_state_t;

  typedef struct packed {
    logic ckOut;
    logic ckOe;
    logic dtOut;
    logic dtOe;
  } usr_pins_t;
endpackage

// ### rtl/usr_sync.sv
// Purpose: Synchronous half-duplex serial transceiver, master receive and slave modes.
// Assumes: Classic Wishbone slave on clk_sys; shift clock pin sampled by clk_sys.
// Notes: Master clock half period is (divisor + 1) clk_sys cycles; LSB first.
// Operation
// - Either receive enable starts reception in synchronous master mode.
// - Data pin is sampled on each falling shift clock edge.
// - Single-word enable in master mode receives one word, then stops.
// - Continuous enable keeps receiving words until software clears it.
// - With both enables set, continuous reception wins.
// - Each received word sets the receive flag; enabled flag raises interrupt.
// - Software reads status before data; clearing continuous enable clears errors.
// - Clock source select clear means slave: shift clock comes from pin.
// - Slave mode shifts on the external clock while the core sleeps.
// - Two writes: first word goes to shifter, second stays, flag clear.
// - After first word, second moves to shifter and transmit flag sets.
// - Slave mode ignores single-word enable; only continuous enable counts.
// - Slave word received in sleep lands in buffer and may interrupt.
// - Transmit flag sets on hand-over, clears only by data write.
// - Shifter-empty status bit reflects transmit shifter, no interrupt.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "usr_map.svh"
module usr_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial pins
  input wire logic shiftClkIn,
  output logic shiftClkOut,
  output logic shiftClkOe,
  input wire logic serDataIn,
  output logic serDataOut,
  output logic serDataOe,
  // Interrupt
  output logic irq
);
  logic rstMeta_r, rstN_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstN_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r <= rstMeta_r;
    end
  end

  // Pin synchronisers; the first stage feeds only the second.
  logic ckMeta_r, ckSync_r, ckPrev_r, dtMeta_r, dtSync_r;
  always_ff @(posedge clk_sys or negedge rstN_r) begin
    if (!rstN_r) begin
      ckMeta_r <= 1'b0;
      ckSync_r <= 1'b0;
      ckPrev_r <= 1'b0;
      dtMeta_r <= 1'b0;
      dtSync_r <= 1'b0;
    end else begin
      ckMeta_r <= shiftClkIn;
      ckSync_r <= ckMeta_r;
      ckPrev_r <= ckSync_r;
      dtMeta_r <= serDataIn;
      dtSync_r <= dtMeta_r;
    end
  end

  // Software-visible state, then bus, pin, sequencer and shifter state.
  logic portEn_r, rx9En_r, swEn_r, contEn_r, addrDet_r, overrun_r, rx9Bit_r;
  logic clkSrc_r, tx9En_r, transmit_enable_bit_r, syncMode_r, hiBaud_r, tx9Bit_r;
  logic rxDone_r, txFull_r;
  logic [7:0] txData_r, rxData_r, ien_r, baudDiv_r;
  logic ack_r, irq_r;
  logic [31:0] dat_r;
  usr_pkg::usr_pins_t pins_r;
  usr_pkg::usr_state_t st_r, stNxt;
  logic [3:0] cnt_r, cntNxt;
  logic [7:0] bcnt_r;
  logic [8:0] rxSh_r, txSh_r;
  logic txPend_r;
  logic txFlag_r;
  logic load, swClr;

  // Bus decode.
  wire busReq = wb_cyc_i & wb_stb_i;
  wire [7:0] idx = wb_adr_i[9:2];
  wire wrOk = busReq & wb_we_i & ack_r & wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire wrIflag = wrOk & (idx == `USR_IDX_IFLAG);
  wire wrRxCtl = wrOk & (idx == `USR_IDX_RXCTL);
  wire wrTxDat = wrOk & (idx == `USR_IDX_TXDAT);
  wire wrIen = wrOk & (idx == `USR_IDX_IEN);
  wire wrTxCtl = wrOk & (idx == `USR_IDX_TXCTL);
  wire wrBaud = wrOk & (idx == `USR_IDX_BAUD);

  // Mode and enables.
  wire portOn = portEn_r & syncMode_r;
  wire master = portOn & clkSrc_r;
  wire rxOn = portOn & (contEn_r | (swEn_r & clkSrc_r));
  wire txOk = portOn & transmit_enable_bit_r & ~rxOn;
  wire shEmpty = (st_r != usr_pkg::ST_TX);
  // The flag is its own register so that it reads clear after reset, before any hand-over.
  wire txEmptyFlag = txFlag_r;
  wire [7:0] iflags = {2'h0, rxDone_r, txEmptyFlag, 4'h0};

  // Gated master clock
  // The data pin passes a two-stage synchroniser, so a divisor below 2 would sample a
  // stale bit from a far end that changes data on the rising edge.
  wire bRun = master & ((st_r != usr_pkg::ST_IDLE) | pins_r.ckOut);
  wire bTick = bRun & (bcnt_r == baudDiv_r);
  wire sRise = ckSync_r & ~ckPrev_r;
  wire sFall = ~ckSync_r & ckPrev_r;
  wire riseEv = clkSrc_r ? (bTick & ~pins_r.ckOut) : (portOn & sRise);
  wire fallEv = clkSrc_r ? (bTick & pins_r.ckOut) : (portOn & sFall);

  wire useNine = (st_r == usr_pkg::ST_RX) ? rx9En_r : tx9En_r;
  wire [3:0] lastBit = useNine ? `USR_LAST_9BIT : `USR_LAST_8BIT;
  wire atLast = (cnt_r == lastBit);
  wire [8:0] rxShNew = {dtSync_r, rxSh_r[8:1]};
  wire wordDone = (st_r == usr_pkg::ST_RX) & rxOn & fallEv & atLast;
  wire rxSet = wordDone & ~rxDone_r;
  wire ovrSet = wordDone & rxDone_r & contEn_r;
  wire [7:0] rxWord = rx9En_r ? rxShNew[7:0] : rxShNew[8:1];

  // Sequencer.
  always_comb begin
    stNxt = st_r;
    cntNxt = cnt_r;
    load = 1'b0;
    swClr = 1'b0;
    case (st_r)
      usr_pkg::ST_IDLE: begin
        if (rxOn) begin
          stNxt = usr_pkg::ST_RX;
          cntNxt = 4'h0;
        end else if (txOk & txFull_r) begin
          stNxt = usr_pkg::ST_TX;
          cntNxt = 4'h0;
          load = 1'b1;
        end
      end
      usr_pkg::ST_RX: begin
        if (!rxOn) begin
          stNxt = usr_pkg::ST_IDLE;
        end else if (fallEv) begin
          cntNxt = atLast ? 4'h0 : 4'(cnt_r + 4'h1);
          if (atLast & ~contEn_r) begin
            stNxt = usr_pkg::ST_IDLE;
            swClr = 1'b1;
          end
        end
      end
      usr_pkg::ST_TX: begin
        if (!txOk) begin
          stNxt = usr_pkg::ST_IDLE;
        end else if (fallEv) begin
          cntNxt = atLast ? 4'h0 : 4'(cnt_r + 4'h1);
          if (atLast & txFull_r) begin
            load = 1'b1;
          end else if (atLast) begin
            stNxt = usr_pkg::ST_IDLE;
          end
        end
      end
      default: stNxt = usr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstN_r) begin
    if (!rstN_r) begin
      st_r <= usr_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      bcnt_r <= 8'h00;
    end else begin
      st_r <= stNxt;
      cnt_r <= cntNxt;
      bcnt_r <= (bRun & ~bTick) ? 8'(bcnt_r + 8'h01) : 8'h00;
    end
  end

  // Shifters. Data changes after a rising edge so the far end samples it on the fall.
  always_ff @(posedge clk_sys or negedge rstN_r) begin
    if (!rstN_r) begin
      rxSh_r <= 9'h000;
      txSh_r <= 9'h000;
      txPend_r <= 1'b0;
    end else begin
      if ((st_r == usr_pkg::ST_RX) & fallEv) rxSh_r <= rxShNew;
      if (load) txSh_r <= {tx9Bit_r, txData_r};
      else if (txPend_r & riseEv) txSh_r <= {1'b0, txSh_r[8:1]};
      txPend_r <= ~load & ((txPend_r & ~riseEv) | ((st_r == usr_pkg::ST_TX) & fallEv & ~atLast));
    end
  end

  // Received word and status flags; a hardware set wins over a software clear.
  always_ff @(posedge clk_sys or negedge rstN_r) begin
    if (!rstN_r) begin
      rxData_r <= `USR_RST_BYTE;
      rx9Bit_r <= 1'b0;
      rxDone_r <= 1'b0;
      overrun_r <= 1'b0;
      txFull_r <= 1'b0;
      txFlag_r <= 1'b0;
    end else begin
      if (rxSet) rxData_r <= rxWord;
      if (rxSet) rx9Bit_r <= rx9En_r & rxShNew[8];
      rxDone_r <= rxSet | (rxDone_r & ~(wrIflag & wd[`USR_B_RXDONE]));
      overrun_r <= ovrSet | (overrun_r & contEn_r);
      txFull_r <= wrTxDat | (txFull_r & ~load);
      txFlag_r <= load | (txFlag_r & ~wrTxDat);
    end
  end

  // Configuration registers.
  always_ff @(posedge clk_sys or negedge rstN_r) begin
    if (!rstN_r) begin
      {portEn_r, rx9En_r, swEn_r, contEn_r, addrDet_r} <= 5'h00;
      {clkSrc_r, tx9En_r, transmit_enable_bit_r, syncMode_r, hiBaud_r, tx9Bit_r} <= 6'h00;
      txData_r <= `USR_RST_BYTE;
      ien_r <= `USR_RST_BYTE;
      baudDiv_r <= `USR_RST_BYTE;
    end else begin
      if (wrRxCtl) begin
        portEn_r <= wd[`USR_B_PORTEN];
        rx9En_r <= wd[`USR_B_RX9EN];
        contEn_r <= wd[`USR_B_CONTEN];
        addrDet_r <= wd[`USR_B_ADDRDET];
      end
      swEn_r <= wrRxCtl ? wd[`USR_B_SWEN] : (swEn_r & ~swClr);
      if (wrTxCtl) begin
        clkSrc_r <= wd[`USR_B_CLKSRC];
        tx9En_r <= wd[`USR_B_TX9EN];
        transmit_enable_bit_r <= wd[`USR_B_TRANSMIT_ENABLE_BIT];
        syncMode_r <= wd[`USR_B_SYNCMODE];
        hiBaud_r <= wd[`USR_B_HIBAUD];
        tx9Bit_r <= wd[`USR_B_TX9BIT];
      end
      if (wrTxDat) txData_r <= wd;
      if (wrIen) ien_r <= wd;
      if (wrBaud) baudDiv_r <= wd;
    end
  end

  // Read selection; framing errors cannot occur in synchronous mode.
  wire [7:0] rxCtlVal = {portEn_r, rx9En_r, swEn_r, contEn_r, addrDet_r, 1'b0, overrun_r,
    rx9Bit_r};
  wire [7:0] txCtlVal = {clkSrc_r, tx9En_r, transmit_enable_bit_r, syncMode_r, 1'b0, hiBaud_r, shEmpty,
    tx9Bit_r};
  wire [7:0] rdVal =
    (idx == `USR_IDX_IFLAG) ? iflags :
    (idx == `USR_IDX_RXCTL) ? rxCtlVal :
    (idx == `USR_IDX_TXDAT) ? txData_r :
    (idx == `USR_IDX_RXDAT) ? rxData_r :
    (idx == `USR_IDX_IEN) ? ien_r :
    (idx == `USR_IDX_TXCTL) ? txCtlVal :
    (idx == `USR_IDX_BAUD) ? baudDiv_r : 8'h00;

  // Bus answer, interrupt and pin drivers, all registered.
  always_ff @(posedge clk_sys or negedge rstN_r) begin
    if (!rstN_r) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      irq_r <= 1'b0;
      pins_r <= '0;
    end else begin
      ack_r <= busReq & ~ack_r;
      if (busReq & ~ack_r) dat_r <= {24'h00_0000, rdVal};
      irq_r <= |(iflags & ien_r);
      pins_r.ckOut <= master & (bTick ? ~pins_r.ckOut : pins_r.ckOut);
      pins_r.ckOe <= master;
      pins_r.dtOut <= txSh_r[0];
      pins_r.dtOe <= portOn & (st_r == usr_pkg::ST_TX) & ~load;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq = irq_r;
  assign shiftClkOut = pins_r.ckOut;
  assign shiftClkOe = pins_r.ckOe;
  assign serDataOut = pins_r.dtOut;
  assign serDataOe = pins_r.dtOe;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstN_r);

  property p_rx_start;
    (st_r == usr_pkg::ST_IDLE) & rxOn |=> (st_r == usr_pkg::ST_RX);
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("receive did not start");
  property p_fall_count;
    (st_r == usr_pkg::ST_RX) & rxOn & fallEv & ~atLast |=> cnt_r == 4'($past(cnt_r) + 4'h1);
  endproperty
  a_fall_count: assert property (p_fall_count) else $error("bit not counted");
  property p_single_stop;
    wordDone & ~contEn_r |=> (st_r == usr_pkg::ST_IDLE) & ~swEn_r;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single word kept going");
  property p_cont_keep;
    wordDone & contEn_r & rxOn |=> (st_r == usr_pkg::ST_RX) && (cnt_r == 4'h0);
  endproperty
  a_cont_keep: assert property (p_cont_keep) else $error("continuous rx stopped");
  property p_flag_set;
    wordDone & ~rxDone_r |=> rxDone_r && (rxData_r == $past(rxWord));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("receive flag or data missing");
  property p_err_clear;
    ~contEn_r |=> ~overrun_r;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("overrun not cleared");
  property p_slave_clk;
    portOn & ~clkSrc_r |=> ~shiftClkOe ##1 ~shiftClkOe;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");
  property p_slave_ignore_sw;
    portOn & ~clkSrc_r & ~contEn_r & (st_r == usr_pkg::ST_IDLE) |=> (st_r != usr_pkg::ST_RX);
  endproperty
  a_slave_ignore_sw: assert property (p_slave_ignore_sw) else $error("slave used sw enable");
  property p_handover;
    load & ~wrTxDat |=> ~txFull_r && txFlag_r ##1 (~txFull_r || $past(wrTxDat));
  endproperty
  a_handover: assert property (p_handover) else $error("transmit flag not set");
  property p_clk_idle;
    master & (st_r == usr_pkg::ST_IDLE) & ~pins_r.ckOut & ~rxOn |=> $stable(shiftClkOut);
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock ran while idle");
  property p_no_sw_clear;
    txFull_r & ~load & ~wrTxDat |=> txFull_r;
  endproperty
  a_no_sw_clear: assert property (p_no_sw_clear) else $error("transmit flag changed");
  property p_irq_cause;
    irq |-> $past((rxDone_r & ien_r[`USR_B_RXDONE]) | (txFlag_r & ien_r[`USR_B_TXEMPTY]));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("spurious interrupt");

  cp_master_single: cover property (wordDone & master & ~contEn_r);
  cp_slave_reload: cover property ((st_r == usr_pkg::ST_TX) & load & ~clkSrc_r);
  cp_overrun: cover property (ovrSet);
  property p_both_cont;
    wordDone & swEn_r & contEn_r & rxOn |=> (st_r == usr_pkg::ST_RX) && swEn_r;
  endproperty
  a_both_cont: assert property (p_both_cont) else $error("both enables did not continue");
  property p_first_load;
    (st_r == usr_pkg::ST_IDLE) & txOk & txFull_r & ~rxOn |=> (st_r == usr_pkg::ST_TX);
  endproperty
  a_first_load: assert property (p_first_load) else $error("first word not loaded");
  property p_slave_shift;
    (st_r == usr_pkg::ST_RX) & ~clkSrc_r & portOn & sFall |=> rxSh_r == $past(rxShNew);
  endproperty
  a_slave_shift: assert property (p_slave_shift) else $error("slave bit not shifted");
  property p_slave_land;
    rxSet & ~clkSrc_r |=> rxDone_r && (rxData_r == $past(rxWord));
  endproperty
  a_slave_land: assert property (p_slave_land) else $error("slave word not in buffer");
  cp_cont_both: cover property (wordDone & swEn_r & contEn_r);
  cp_slave_rx: cover property (rxSet & ~clkSrc_r);
endmodule // usr_sync

// ### verif/usr_far_dev.sv
// Purpose: Far-end synchronous serial device facing usr_sync.
// Assumes: It changes data after rising clock edges, LSB first.
// Notes: It samples at falls, which leaves room for the design's input synchroniser.
`timescale 1ns/1ps
module usr_far_dev (
  // Design side
  input wire logic ckOut,
  input wire logic ckOe,
  input wire logic dtOut,
  input wire logic dtOe,
  // Resolved pins
  output logic ckWire,
  output logic dtWire
);
  logic extClk = 1'b0;
  logic [16:0] sendReg = 17'h00000;
  logic [7:0] gotWord = 8'h00;
  assign ckWire = ckOe ? ckOut : extClk;
  // Spent bits come back inverted, so a released line never looks held.
  assign dtWire = dtOe ? dtOut : sendReg[0];
  always @(posedge ckWire) begin
    sendReg <= {~sendReg[0], sendReg[16:1]};
  end
  always @(negedge ckWire) begin
    gotWord <= {dtWire, gotWord[7:1]};
  end
  // The pad bit is dropped at the first rise, before the first sampling fall.
  task automatic load(input logic [15:0] w);
    sendReg = {w, 1'b0};
  endtask
  // Slave clock of 200 ns that stands low between frames.
  // Edges sit 10 ns off the system clock edge, so no pin change races a sampling edge.
  task automatic frame(input int n);
    #10;
    repeat (n) begin
      #100 extClk = 1'b1;
      #100 extClk = 1'b0;
    end
  endtask
endmodule // usr_far_dev

// ### verif/usr_sync_tb.sv
// Purpose: Self-checking bench for usr_sync.
// Assumes: The far device drives frames; registers are reached over classic Wishbone.
// Notes: Words and the divisor come from a fixed-seed shift register.
`timescale 1ns/1ps
module usr_sync_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [9:0] wbAdr = 10'h000;
  logic [31:0] wbDatI = 32'h00000000;
  logic [31:0] wbDatO;
  logic wbAck, ckO, ckE, dtO, dtE, ckW, dtW, irq;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] rnd = 32'h0001651B;
  logic [7:0] v, w0, w1, div;
  logic [7:0] regIdx [7] = '{8'h0C, 8'h19, 8'h1A, 8'h8C, 8'h98, 8'h99, 8'h55};
  logic [7:0] regRst [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  usr_sync i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .shiftClkIn(ckW), .shiftClkOut(ckO), .shiftClkOe(ckE),
    .serDataIn(dtW), .serDataOut(dtO), .serDataOe(dtE), .irq(irq));
  usr_far_dev i_far (.ckOut(ckO), .ckOe(ckE), .dtOut(dtO), .dtOe(dtE), .ckWire(ckW),
    .dtWire(dtW));
  always #12.5 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // One classic cycle, entered just after a rising edge.
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbDatI <= {24'h000000, d};
    @(posedge clk_sys);
    while (wbAck !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 40) errors++;
    v = wbDatO[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd8(input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk8(v, e);
  endtask
  task automatic rdBit(input logic [7:0] idx, input int b, input logic e);
    wb(1'b0, idx, 8'h00);
    chk1(v[b], e);
  endtask
  task automatic waitIrq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim) errors++;
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wb(1'b1, 8'h55, 8'hFF);
    wb(1'b1, 8'h1A, 8'hA5);
    foreach (regIdx[i]) begin
      rd8(regIdx[i], regRst[i]);
    end
    div = rnd[7:0];
    wb(1'b1, 8'h99, div);
    rd8(8'h99, div);
    // Master single word at the fastest divisor the pin synchroniser can follow.
    rnd = lfsr(rnd);
    w0 = rnd[7:0];
    i_far.load({8'h00, w0});
    wb(1'b1, 8'h99, 8'h02);
    wb(1'b1, 8'h98, 8'h90);
    wb(1'b1, 8'h8C, 8'h20);
    wb(1'b1, 8'h18, 8'hA0);
    @(posedge clk_sys);
    chk1(ckE, 1'b1);
    waitIrq(300);
    chk1(irq, 1'b1);
    rd8(8'h18, 8'h80);
    rd8(8'h1A, w0);
    v = 8'h00;
    repeat (20) begin
      @(posedge clk_sys);
      v = v | {7'h00, ckO};
    end
    chk8(v, 8'h00);
    wb(1'b1, 8'h0C, 8'h20);
    rd8(8'h0C, 8'h00);
    chk1(irq, 1'b0);
    // Continuous with both enables, then an overrun.
    div = 8'h02 + {6'h00, rnd[9:8]};
    rnd = lfsr(rnd);
    w0 = rnd[7:0];
    w1 = rnd[15:8];
    i_far.load({w1, w0});
    wb(1'b1, 8'h99, div);
    wb(1'b1, 8'h18, 8'hB0);
    waitIrq(400);
    rd8(8'h1A, w0);
    wb(1'b1, 8'h0C, 8'h20);
    @(posedge clk_sys);
    waitIrq(400);
    rd8(8'h1A, w1);
    repeat (200) @(posedge clk_sys);
    rdBit(8'h18, 1, 1'b1);
    rd8(8'h1A, w1);
    wb(1'b1, 8'h18, 8'h80);
    rdBit(8'h18, 1, 1'b0);
    wb(1'b1, 8'h0C, 8'h20);
    // Slave receive: single-word enable alone does nothing.
    wb(1'b1, 8'h98, 8'h10);
    wb(1'b1, 8'h18, 8'hA0);
    chk1(ckE, 1'b0);
    rnd = lfsr(rnd);
    w0 = rnd[7:0];
    i_far.load({8'h00, w0});
    i_far.frame(8);
    repeat (10) @(posedge clk_sys);
    chk1(irq, 1'b0);
    wb(1'b1, 8'h18, 8'h90);
    i_far.load({8'h00, w0});
    i_far.frame(8);
    waitIrq(50);
    chk1(irq, 1'b1);
    rd8(8'h1A, w0);
    wb(1'b1, 8'h0C, 8'h20);
    wb(1'b1, 8'h18, 8'h80);
    // Slave transmit of two buffered words.
    w1 = rnd[15:8];
    wb(1'b1, 8'h98, 8'h30);
    wb(1'b1, 8'h8C, 8'h10);
    wb(1'b1, 8'h19, w0);
    wb(1'b1, 8'h19, w1);
    rdBit(8'h0C, 4, 1'b0);
    chk1(irq, 1'b0);
    chk1(dtO, w0[0]);
    rdBit(8'h98, 1, 1'b0);
    i_far.frame(8);
    repeat (10) @(posedge clk_sys);
    chk8(i_far.gotWord, w0);
    chk1(irq, 1'b1);
    wb(1'b1, 8'h0C, 8'h10);
    rdBit(8'h0C, 4, 1'b1);
    i_far.frame(8);
    repeat (10) @(posedge clk_sys);
    chk8(i_far.gotWord, w1);
    rdBit(8'h98, 1, 1'b1);
    wb(1'b1, 8'h8C, 8'h00);
    @(posedge clk_sys);
    chk1(irq, 1'b0);
    wb(1'b1, 8'h98, 8'h10);
    wb(1'b1, 8'h19, w0);
    rdBit(8'h0C, 4, 1'b0);
    give_verdict();
  end
endmodule // usr_sync_tb
